// ===== dv/dmid_decode_props.sv
// Purpose: timing and operand checks on the decode outputs
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to every instance of the decoder
`timescale 1ns/1ps
module dmid_decode_props
    import dmid_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic srst, // synchronous reset
    input wire logic instrReady, // decoder takes a word
    input wire logic decValid, // decoded instruction valid
    input wire dmid_dec_type decOut, // decoded fields
    input wire logic [1:0] decCycles, // cycles of instruction
    input wire logic fillerNop, // filler cycle
    input wire logic illegal // operand out of range
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // returns hold the port for two filler cycles
    AST_RET_FILL: assert property (decValid && decCycles == CYC_3 |->
        !instrReady ##1 fillerNop ##1 fillerNop)
        else $error("three-cycle op lacks two fillers");
    AST_TWO_FILL: assert property (decValid && decCycles == CYC_2 &&
        decOut.cls != CL_DWORD |=> fillerNop)
        else $error("two-cycle op lacks a filler");
    AST_FILL_QUIET: assert property (fillerNop |-> !decOut.wrEn)
        else $error("filler cycle may write");
    AST_PROG_LSB: assert property (decValid && decOut.cls == CL_DWORD &&
        !illegal |-> decCycles == CYC_2 && !decOut.progAddr[0])
        else $error("double word address or cycles wrong");
    AST_SQR: assert property (decValid && decOut.cls == CL_SQR && !illegal
        |-> decOut.mulA == decOut.mulB && decOut.mulA[3:2] == 2'h1)
        else $error("square register out of set");
    AST_PAIR: assert property (decValid && decOut.cls == CL_MAC && !illegal
        |-> decOut.mulA < decOut.mulB && decOut.mulA[3:2] == 2'h1 &&
        decOut.mulB[3:2] == 2'h1)
        else $error("multiply pair out of set");
    AST_PF_DST: assert property (decValid && decOut.cls == CL_MAC |->
        decOut.xDst[3:2] == 2'h1 && decOut.yDst[3:2] == 2'h1)
        else $error("prefetch destination out of set");
    AST_XPF: assert property (decValid && decOut.xPf.en |->
        decOut.xPf.addrReg[3:1] == 3'h4)
        else $error("x prefetch register wrong");
    AST_YPF: assert property (decValid && decOut.yPf.en |->
        decOut.yPf.addrReg[3:1] == 3'h5)
        else $error("y prefetch register wrong");
    AST_BYTE_LIT: assert property (decValid && decOut.cls == CL_LIT &&
        decOut.byteMode && !illegal |-> decOut.litU <= 16'h00ff)
        else $error("byte literal above limit");
endmodule
bind dmid_decode dmid_decode_props i_props (.clk_sys(clk_sys),
    .srst(srst), .instrReady(instrReady), .decValid(decValid),
    .decOut(decOut), .decCycles(decCycles), .fillerNop(fillerNop),
    .illegal(illegal));

// ===== dv/tb_dmid_decode.sv
// Purpose: self-checking bench for the decode block
// Assumes: opcodes and field positions of the shared package
// Notes: words and register strobes driven right after rising edges
`timescale 1ns/1ps
module tb_dmid_decode import dmid_pkg::*;;
    logic clk_sys = 1'b0; // system clock
    logic srst = 1'b1; // reset, held two cycles
    logic instrValid = 1'b0, condTrue = 1'b0, skipTaken = 1'b0;
    logic [23:0] instrWord = 24'h000000; // offered word
    dmid_fupd_type flagUpd = '0; // flag results
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWr = 1'b0, regRd = 1'b0;
    logic [15:0] regRdata;
    logic instrReady, decValid, fillerNop, illegal;
    dmid_dec_type decOut;
    logic [1:0] decCycles;
    dmid_flags_type mcuFlags;
    dmid_dsp_type dspFlags;
    int failures = 0, compares = 0;
    // {cond, illegal, cycles, word} for single words
    logic [27:0] sw [16] = '{{2'h0, CYC_3, OP_RET, 16'h0000},
        {2'h0, CYC_3, OP_RETI, 16'h0000}, {2'h0, CYC_2, OP_BRA, 16'h0000},
        {2'h0, CYC_2, OP_CALLI, 16'h0000}, {2'h0, CYC_2, OP_TBL, 16'h0000},
        {2'h0, CYC_2, OP_MOVD, 16'h0000}, {2'h2, CYC_2, OP_BRC, 16'h0000},
        {2'h0, CYC_1, OP_BRC, 16'h0000}, {2'h1, CYC_1, 8'hc0, 16'h6000},
        {2'h1, CYC_1, 8'hc3, 16'h0000}, {2'h0, CYC_1, 8'hc1, 16'h5000},
        {2'h1, CYC_1, OP_LIT, 16'h5000}, {2'h0, CYC_1, OP_LIT, 16'h1000},
        {2'h0, CYC_1, OP_NOP, 16'h0005}, {2'h0, CYC_1, OP_SQR, 16'h0000},
        {2'h0, CYC_1, OP_LIT, 16'h4ff0}};
    // {illegal, low address word, second word}
    logic [40:0] dw [3] = '{{1'b0, 16'h1234, 24'h000005},
        {1'b1, 16'h1235, 24'h000005}, {1'b1, 16'h1234, 24'h010005}};
    always #5 clk_sys = ~clk_sys;
    dmid_decode i_dut (.clk_sys(clk_sys), .srst(srst),
        .instrValid(instrValid), .instrWord(instrWord),
        .condTrue(condTrue), .skipTaken(skipTaken), .flagUpd(flagUpd),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .instrReady(instrReady),
        .decValid(decValid), .decOut(decOut), .decCycles(decCycles),
        .fillerNop(fillerNop), .illegal(illegal), .mcuFlags(mcuFlags),
        .dspFlags(dspFlags));
    // compare one value, count and report
    task chk(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // offer a word, return at the edge that takes it
    task put(input logic [23:0] w, input logic c);
        int n;
        n = 0;
        if (!instrValid) instrValid <= 1'b1;
        instrWord <= w;
        condTrue <= c;
        skipTaken <= c;
        do begin @(posedge clk_sys); n++; end while (!instrReady && n < 8);
        if (!instrReady) begin failures++; tally_and_finish(); end
    endtask
    // release the port and wait for the decode pulse
    task getdec;
        int n;
        n = 0;
        instrValid <= 1'b0;
        #1;
        while (!decValid && n < 6) begin @(posedge clk_sys); #1; n++; end
        if (!decValid) begin failures++; tally_and_finish(); end
        @(posedge clk_sys);
    endtask
    task rd(input logic [3:0] a, input logic [15:0] exp);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        @(posedge clk_sys);
        chk(regRdata, exp);
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    // main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        rd(REG_CTRL, CTRL_RST);
        wr(REG_FLAGS, 16'hffff);
        rd(REG_FLAGS, 16'h0000);
        rd(4'h9, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            put(sw[i][23:0], sw[i][27]);
            getdec();
            chk({illegal, decCycles}, sw[i][26:24]);
        end
        for (int i = 0; i < 3; i++) begin
            put({OP_DWORD, dw[i][39:24]}, 1'b0);
            put(dw[i][23:0], 1'b0);
            getdec();
            chk({illegal, decCycles}, {dw[i][40], CYC_2});
            if (!dw[i][40]) chk(decOut.progAddr, 23'h051234);
        end
        put({OP_SKIP, 16'h0000}, 1'b1);
        getdec();
        put({OP_DWORD, 16'h1234}, 1'b0);
        put(24'h000005, 1'b0);
        instrValid <= 1'b0;
        #1;
        chk({decValid, fillerNop}, 2'h3);
        @(posedge clk_sys);
        put({OP_FILE, 16'h0000}, 1'b0);
        flagUpd <= {2'h2, 5'h1e, 4'hf};
        getdec();
        flagUpd <= '0;
        rd(REG_FLAGS, 16'h01fe);
        put({OP_FILE, 16'h0000}, 1'b0);
        flagUpd <= {2'h3, 5'h01, 4'h0};
        getdec();
        flagUpd <= '0;
        @(posedge clk_sys);
        chk({dspFlags, mcuFlags}, 9'h000);
        // decoding switched off: a return comes out as a plain nop
        wr(REG_CTRL, 16'h0000);
        put({OP_RET, 16'h0000}, 1'b0);
        getdec();
        chk({decOut.wrEn, decCycles}, {1'b0, CYC_1});
        tally_and_finish();
    end
endmodule

// ===== rtl/dmid_decode.sv
// Purpose: instruction decode and cycle timing for the 16-bit DSP core
// Assumes: one program word offered per cycle while instrReady is high
// Notes: filler cycles come out as no-operations with writes disabled
//
// Summary of operation
// (RULE_01) double word is 48 bits, top byte zero
// (RULE_02) lone second word decodes as no-operation
// (RULE_03) one cycle, two when taken or jumping
// (RULE_04) branches, tables, returns take two or three
// (RULE_05) taken skip: two or three cycles by length
// (RULE_06) double-word moves and instructions take two
// (RULE_07) shift names accumulator, amount register or literal
// (RULE_08) accumulator field selects A or B
// (RULE_09) write-back to W13 or post-increment by two
// (RULE_10) bit select is four bits, 0 to 15
// (RULE_11) file address spans zero to 0x1fff
// (RULE_12) ten-bit literal limited to 255 in byte mode
// (RULE_13) program address literal least bit is zero
// (RULE_14) signed literals decoded in two's complement
// (RULE_15) five arithmetic flags, zero flag sticky
// (RULE_16) four accumulator overflow and saturation flags
// (RULE_17) file ops use W0 as default register
// (RULE_18) register fields select W0 to W15
// (RULE_19) square uses one of W4 to W7
// (RULE_20) multiply uses six pairs of W4..W7
// (RULE_21) x prefetch: W8/W9 modes, W9+W12, none
// (RULE_22) y prefetch: W10/W11 modes, W11+W12, none
// (RULE_23) prefetch destinations W4..W7, divide direct registers
// (RULE_24) filler cycles change no state
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module dmid_decode
    import dmid_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic srst, // synchronous reset
    input wire logic instrValid, // program word offered
    input wire logic [WORD_W-1:0] instrWord, // program word
    input wire logic condTrue, // condition of current branch holds
    input wire logic skipTaken, // current skip instruction skips
    input wire dmid_fupd_type flagUpd, // flag results from execution
    input wire logic [3:0] regAddr, // register address
    input wire logic [15:0] regWdata, // register write data
    input wire logic regWr, // register write strobe
    input wire logic regRd, // register read strobe
    output logic [15:0] regRdata, // read data, cycle after strobe
    output logic instrReady, // decoder takes a word this cycle
    output logic decValid, // decoded instruction valid
    output dmid_dec_type decOut, // decoded fields
    output logic [1:0] decCycles, // cycles of this instruction
    output logic fillerNop, // filler or skipped no-operation
    output logic illegal, // operand out of range
    output dmid_flags_type mcuFlags, // arithmetic status flags
    output dmid_dsp_type dspFlags // accumulator status flags
);
    typedef enum logic [1:0] {ST_RUN, ST_WORD2, ST_FILL} dmid_state_type;

    dmid_state_type state_q; // sequencing state
    logic [15:0] ctrl_q; // control register
    logic [15:0] rdata_q; // read data
    logic ready_q; // word acceptance
    logic decValid_q; // output valid
    dmid_dec_type dec_q; // decoded output
    logic [1:0] cyc_q; // cycle count output
    logic nop_q; // filler output
    logic ill_q; // illegal output
    logic [1:0] fill_q; // filler cycles left
    logic skipPend_q; // next word is skipped
    logic swallow_q; // second word of a skipped one
    logic [WORD_W-1:0] first_q; // first word of double word
    logic [7:0] lastOpc_q; // last opcode seen
    dmid_flags_type mcu_q; // arithmetic flags
    dmid_dsp_type dsp_q; // accumulator flags
    dmid_dec_type dec_d; // single-word decode
    dmid_dec_type dw_d; // double-word decode
    dmid_class_type cls; // class of offered word
    logic [1:0] cyc_d; // cycles of offered word
    logic ill_d; // single-word operand error
    logic dwIll_d; // double-word operand error
    logic take; // a word is accepted
    logic en; // decoding enabled

    // opcode to class
    function automatic dmid_class_type classOf(input logic [7:0] opc);
        dmid_class_type c;
        c = CL_PLAIN;
        if (opc[7:2] == OP_MAC_GRP) begin
            c = CL_MAC;
        end else begin
            case (opc)
                OP_NOP: c = CL_NOP;
                OP_DWORD: c = CL_DWORD;
                OP_MOVD: c = CL_MOVD;
                OP_BRC: c = CL_BRC;
                OP_BRA, OP_CALLI: c = CL_BRA;
                OP_TBL: c = CL_TBL;
                OP_RET, OP_RETI: c = CL_RET;
                OP_SKIP: c = CL_SKIP;
                OP_FILE: c = CL_FILE;
                OP_BIT: c = CL_BIT;
                OP_LIT: c = CL_LIT;
                OP_SLIT: c = CL_SLIT;
                OP_SL16: c = CL_SL16;
                OP_SQR: c = CL_SQR;
                OP_SHIFT: c = CL_SHIFT;
                OP_DIV: c = CL_DIV;
                default: c = CL_PLAIN;
            endcase
        end
        return c;
    endfunction

    // prefetch code to address mode, used for x and y space
    function automatic dmid_pf_type pfDecode(input logic [3:0] code,
                                             input logic [3:0] base);
        dmid_pf_type p;
        logic [3:0] k;
        p = '0;
        k = (code < PF_GRP) ? code : code - PF_GRP;
        if (code == PF_NONE) begin
            p.en = 1'b0; // no prefetch
        end else if (code == PF_IDX) begin
            p.en = 1'b1;
            p.addrReg = base + 4'h1;
            p.indexed = 1'b1;
        end else begin
            p.en = 1'b1;
            p.addrReg = (code < PF_GRP) ? base : base + 4'h1;
            case (k)
                4'h0: p.step = 4'sh6;
                4'h1: p.step = 4'sh4;
                4'h2: p.step = 4'sh2;
                4'h3: p.step = 4'sh0;
                4'h4: p.step = -4'sh6;
                4'h5: p.step = -4'sh4;
                default: p.step = -4'sh2;
            endcase
        end
        return p;
    endfunction

    assign cls = classOf(instrWord[OPC_LSB +: OPC_W]);
    assign en = ctrl_q[CTRL_EN_BIT];
    assign take = instrValid && ready_q;

    // single-word field decode and cycle count
    always_comb begin
        logic [2:0] pr;
        pr = instrWord[PAIR_LSB +: 3];
        dec_d = '0;
        ill_d = 1'b0;
        cyc_d = CYC_1; // RULE_03
        dec_d.cls = cls;
        dec_d.wrEn = (cls != CL_NOP);
        dec_d.ws = instrWord[WS_LSB +: 4]; // RULE_18
        dec_d.wd = instrWord[WD_LSB +: 4]; // RULE_18
        dec_d.wb = instrWord[WB_LSB +: 4]; // RULE_18
        dec_d.byteMode = instrWord[BYTE_BIT];
        dec_d.accB = instrWord[ACC_BIT]; // RULE_08
        case (cls)
            CL_BRC: cyc_d = condTrue ? CYC_2 : CYC_1; // RULE_03
            CL_BRA, CL_TBL: cyc_d = CYC_2; // RULE_04
            CL_RET: cyc_d = CYC_3; // RULE_04
            CL_MOVD: cyc_d = CYC_2; // RULE_06
            CL_FILE: begin
                dec_d.fileAddr = instrWord[FILE_W-1:0]; // RULE_11
                dec_d.wb = W0; // RULE_17
                dec_d.wd = instrWord[FILE_DST_BIT] ? W0 : W0; // RULE_17
                dec_d.byteMode = ~instrWord[FILE_DST_BIT];
            end
            CL_BIT: dec_d.bitSel = instrWord[BITSEL_LSB +: 4]; // RULE_10
            CL_LIT: begin
                dec_d.litU = {6'h00, instrWord[UNSIGNED_LITERAL_10_LSB +: 10]};
                ill_d = instrWord[BYTE_BIT]
                    && (instrWord[UNSIGNED_LITERAL_10_LSB +: 10] > LIT_BYTE_MAX); // RULE_12
            end
            CL_SLIT: dec_d.litS = {{6{instrWord[UNSIGNED_LITERAL_10_LSB + 9]}},
                instrWord[UNSIGNED_LITERAL_10_LSB +: 10]}; // RULE_14
            CL_SL16: begin
                dec_d.litS = instrWord[15:0]; // RULE_14
                dec_d.litU = instrWord[15:0]; // RULE_12
            end
            CL_MAC: begin
                case (pr) // RULE_20
                    3'h0: {dec_d.mulA, dec_d.mulB} = {W4, W4 + 4'h1};
                    3'h1: {dec_d.mulA, dec_d.mulB} = {W4, W4 + 4'h2};
                    3'h2: {dec_d.mulA, dec_d.mulB} = {W4, W4 + 4'h3};
                    3'h3: {dec_d.mulA, dec_d.mulB} = {W4 + 4'h1, W4 + 4'h2};
                    3'h4: {dec_d.mulA, dec_d.mulB} = {W4 + 4'h1, W4 + 4'h3};
                    default: {dec_d.mulA, dec_d.mulB} = {W4 + 4'h2, W4 + 4'h3};
                endcase
                ill_d = (pr > PAIR_MAX); // RULE_20
                dec_d.xPf = pfDecode(instrWord[XPF_LSB +: 4], W8); // RULE_21
                dec_d.yPf = pfDecode(instrWord[YPF_LSB +: 4], W10); // RULE_22
                dec_d.xDst = W4 + {2'h0, instrWord[XD_LSB +: 2]}; // RULE_23
                dec_d.yDst = W4 + {2'h0, instrWord[YD_LSB +: 2]}; // RULE_23
                case (instrWord[OPC_LSB + AWB_LSB +: 2]) // RULE_09
                    2'h1: dec_d.accWb = AWB_DIRECT;
                    2'h2: dec_d.accWb = AWB_POSTINC;
                    2'h3: begin
                        dec_d.accWb = AWB_NONE;
                        ill_d = 1'b1; // no such write-back
                    end
                    default: dec_d.accWb = AWB_NONE;
                endcase
                if (dec_d.accWb != AWB_NONE) begin
                    dec_d.wd = W13; // RULE_09
                end
            end
            CL_SQR: begin
                dec_d.mulA = W4 + {2'h0, instrWord[1:0]}; // RULE_19
                dec_d.mulB = W4 + {2'h0, instrWord[1:0]}; // RULE_19
            end
            CL_SHIFT: begin
                dec_d.shiftByLit = instrWord[SHL_BIT]; // RULE_07
                dec_d.litS = {{10{instrWord[SHAMT_LSB + 5]}},
                    instrWord[SHAMT_LSB +: 6]}; // RULE_07
            end
            CL_DIV: begin
                dec_d.wb = instrWord[WM_LSB +: 4]; // RULE_23
                dec_d.ws = instrWord[WS_LSB +: 4]; // RULE_23
            end
            default: cyc_d = CYC_1;
        endcase
    end

    // double-word decode from held first word and second word
    always_comb begin
        dw_d = '0;
        dw_d.cls = CL_DWORD;
        dw_d.wrEn = 1'b1;
        dw_d.progAddr = {instrWord[HI_ADDR_W-1:0], first_q[15:0]};
        dwIll_d = (instrWord[WORD_W-1:ZERO_LSB] != 8'h00) // RULE_01
            || first_q[0]; // RULE_13
    end

    // sequencing: fetch, second word, filler and skip
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= ST_RUN;
            ready_q <= 1'b0;
            decValid_q <= 1'b0;
            dec_q <= '0;
            cyc_q <= CYC_1;
            nop_q <= 1'b0;
            ill_q <= 1'b0;
            fill_q <= 2'h0;
            skipPend_q <= 1'b0;
            swallow_q <= 1'b0;
            first_q <= '0;
        end else begin
            ready_q <= 1'b1;
            decValid_q <= 1'b0;
            nop_q <= 1'b0;
            ill_q <= 1'b0;
            cyc_q <= CYC_1;
            dec_q <= '0; // idle output carries no writes
            case (state_q)
                ST_RUN: begin
                    if (take) begin
                        decValid_q <= 1'b1;
                        if (skipPend_q) begin
                            // skipped word runs as a nop
                            skipPend_q <= 1'b0;
                            nop_q <= 1'b1; // RULE_05 RULE_24
                            if (cls == CL_DWORD) begin
                                swallow_q <= 1'b1; // RULE_05
                                state_q <= ST_WORD2;
                            end
                        end else if (!en || cls == CL_NOP) begin
                            dec_q.cls <= CL_NOP; // RULE_02
                        end else if (cls == CL_DWORD) begin
                            first_q <= instrWord;
                            decValid_q <= 1'b0;
                            state_q <= ST_WORD2;
                        end else begin
                            dec_q <= dec_d;
                            cyc_q <= cyc_d;
                            ill_q <= ill_d;
                            skipPend_q <= (cls == CL_SKIP) && skipTaken;
                            if (cyc_d != CYC_1) begin
                                fill_q <= cyc_d - CYC_1; // RULE_03 RULE_04
                                ready_q <= 1'b0;
                                state_q <= ST_FILL;
                            end
                        end
                    end
                end
                ST_WORD2: begin
                    if (instrValid) begin
                        decValid_q <= 1'b1;
                        state_q <= ST_RUN;
                        swallow_q <= 1'b0;
                        if (swallow_q) begin
                            nop_q <= 1'b1; // RULE_05 RULE_24
                        end else begin
                            dec_q <= dw_d;
                            cyc_q <= CYC_2; // RULE_06
                            ill_q <= dwIll_d; // RULE_01 RULE_13
                        end
                    end
                end
                ST_FILL: begin
                    // filler cycle: nop with writes off
                    decValid_q <= 1'b1;
                    nop_q <= 1'b1; // RULE_03 RULE_24
                    fill_q <= fill_q - 2'h1;
                    if (fill_q != 2'h1) begin
                        ready_q <= 1'b0;
                    end else begin
                        state_q <= ST_RUN;
                    end
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    // status flags, untouched while a nop or filler is out
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mcu_q <= '0;
            dsp_q <= '0;
        end else if (flagUpd.valid && dec_q.wrEn && !nop_q) begin // RULE_24
            mcu_q.c <= flagUpd.mcu.c; // RULE_15
            mcu_q.dc <= flagUpd.mcu.dc;
            mcu_q.n <= flagUpd.mcu.n;
            mcu_q.ov <= flagUpd.mcu.ov;
            // sticky zero may only be cleared
            mcu_q.z <= flagUpd.sticky ? (mcu_q.z & flagUpd.mcu.z)
                                      : flagUpd.mcu.z; // RULE_15
            dsp_q <= flagUpd.dsp; // RULE_16
        end
    end

    // last accepted opcode for software
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lastOpc_q <= 8'h00;
        end else if (take) begin
            lastOpc_q <= instrWord[OPC_LSB +: OPC_W];
        end
    end

    // control register write
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrl_q <= CTRL_RST;
        end else if (regWr && regAddr == REG_CTRL) begin
            ctrl_q <= {15'h0000, regWdata[CTRL_EN_BIT]};
        end
    end

    // register read, data in the following cycle only
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_q <= 16'h0000;
        end else if (regRd) begin
            case (regAddr)
                REG_CTRL: rdata_q <= ctrl_q;
                REG_FLAGS: rdata_q <= {7'h00, dsp_q, mcu_q};
                REG_LAST: rdata_q <= {3'h0, ill_q, cyc_q, state_q, lastOpc_q};
                default: rdata_q <= 16'h0000; // unmapped reads zero
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign regRdata = rdata_q;
    assign instrReady = ready_q;
    assign decValid = decValid_q;
    assign decOut = dec_q;
    assign decCycles = cyc_q;
    assign fillerNop = nop_q;
    assign illegal = ill_q;
    assign mcuFlags = mcu_q;
    assign dspFlags = dsp_q;
endmodule

// ===== rtl/dmid_pkg.sv
// Purpose: constants and types for the instruction decode block
// Assumes: 24-bit program words, 16 working registers
// Notes: opcode values are local choices of this decoder
package dmid_pkg;
    localparam int WORD_W = 24; // program word width
    localparam int OPC_LSB = 16; // opcode field
    localparam int OPC_W = 8;
    localparam int WS_LSB = 0; // source register field
    localparam int WD_LSB = 7; // destination register field
    localparam int WB_LSB = 11; // base register field
    localparam int WM_LSB = 4; // dividend register field
    localparam int FILE_W = 13; // file register address width
    localparam int FILE_DST_BIT = 13; // 0: result to default_work_reg
    localparam int BITSEL_LSB = 12; // bit_select_field
    localparam int UNSIGNED_LITERAL_10_LSB = 4; // ten-bit literal field
    localparam int BYTE_BIT = 14; // byte mode select
    localparam int ACC_BIT = 15; // 0: acc A, 1: acc B
    localparam int PAIR_LSB = 12; // multiply pair field
    localparam int XPF_LSB = 8; // x prefetch code
    localparam int YPF_LSB = 4; // y prefetch code
    localparam int XD_LSB = 2; // x prefetch destination
    localparam int YD_LSB = 0; // y prefetch destination
    localparam int SHL_BIT = 14; // 1: shift amount is a literal
    localparam int SHAMT_LSB = 4; // six-bit shift literal
    localparam int AWB_LSB = 0; // write-back code, in opcode low bits
    localparam int HI_ADDR_W = 7; // address bits in second word
    localparam int ZERO_LSB = 16; // must-be-zero bits of second word
    localparam logic [9:0] LIT_BYTE_MAX = 10'h0ff; // byte literal limit
    localparam logic [3:0] W0 = 4'h0;
    localparam logic [3:0] W4 = 4'h4;
    localparam logic [3:0] W8 = 4'h8;
    localparam logic [3:0] W10 = 4'ha;
    localparam logic [3:0] W12 = 4'hc;
    localparam logic [3:0] W13 = 4'hd;
    localparam logic [3:0] PF_NONE = 4'hf; // no prefetch
    localparam logic [3:0] PF_IDX = 4'he; // second register plus W12
    localparam logic [3:0] PF_GRP = 4'h7; // codes per base register
    localparam logic [2:0] PAIR_MAX = 3'h5; // six legal pairs
    // opcodes
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_CALLI = 8'h01;
    localparam logic [7:0] OP_DWORD = 8'h02;
    localparam logic [7:0] OP_MOVD = 8'h03;
    localparam logic [7:0] OP_RET = 8'h06;
    localparam logic [7:0] OP_RETI = 8'h07;
    localparam logic [7:0] OP_TBL = 8'h0a;
    localparam logic [7:0] OP_BRC = 8'h37;
    localparam logic [7:0] OP_BRA = 8'h38;
    localparam logic [7:0] OP_FILE = 8'h40;
    localparam logic [7:0] OP_BIT = 8'ha0;
    localparam logic [7:0] OP_SKIP = 8'ha6;
    localparam logic [7:0] OP_LIT = 8'hb0;
    localparam logic [7:0] OP_SLIT = 8'hb1;
    localparam logic [7:0] OP_SL16 = 8'hb2;
    localparam logic [5:0] OP_MAC_GRP = 6'h30; // opcodes c0..c3
    localparam logic [7:0] OP_SQR = 8'hc4;
    localparam logic [7:0] OP_SHIFT = 8'hc8;
    localparam logic [7:0] OP_DIV = 8'hd8;
    // cycle counts
    localparam logic [1:0] CYC_1 = 2'h1;
    localparam logic [1:0] CYC_2 = 2'h2;
    localparam logic [1:0] CYC_3 = 2'h3;
    // register port
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_FLAGS = 4'h1;
    localparam logic [3:0] REG_LAST = 4'h2;
    localparam int CTRL_EN_BIT = 0;
    localparam logic [15:0] CTRL_RST = 16'h0001;
    typedef enum logic [4:0] {CL_NOP, CL_PLAIN, CL_DWORD, CL_MOVD, CL_BRC,
        CL_BRA, CL_TBL, CL_RET, CL_SKIP, CL_FILE, CL_BIT, CL_LIT, CL_SLIT,
        CL_SL16, CL_MAC, CL_SQR, CL_SHIFT, CL_DIV} dmid_class_type;
    typedef enum logic [1:0] {AWB_NONE, AWB_DIRECT, AWB_POSTINC}
        dmid_awb_type;
    typedef struct packed {
        logic en; // prefetch active
        logic [3:0] addrReg; // address register
        logic indexed; // offset by W12
        logic signed [3:0] step; // post-change in bytes
    } dmid_pf_type;
    typedef struct packed {
        logic c, dc, n, ov, z;
    } dmid_flags_type;
    typedef struct packed {
        logic oa, ob, sa, sb;
    } dmid_dsp_type;
    typedef struct packed {
        logic valid; // execution reports new flags
        logic sticky; // zero flag may only be cleared
        dmid_flags_type mcu;
        dmid_dsp_type dsp;
    } dmid_fupd_type;
    typedef struct packed {
        dmid_class_type cls;
        logic wrEn; // may change registers, memory or flags
        logic byteMode;
        logic accB;
        dmid_awb_type accWb;
        logic [3:0] wb, ws, wd;
        logic [12:0] fileAddr;
        logic [3:0] bitSel;
        logic [15:0] litU; // unsigned literal
        logic [15:0] litS; // sign-extended literal
        logic [22:0] progAddr;
        logic [3:0] mulA, mulB;
        dmid_pf_type xPf, yPf;
        logic [3:0] xDst, yDst;
        logic shiftByLit;
    } dmid_dec_type;
endpackage
